//--- bench/drive_output_function_sequencer_test.sv
// self-checking bench: registers, timer, analog on/off, brake sequence
// assumes a 4-cycle tick so delays stay short
`timescale 1ns/1ps
module drive_output_function_sequencer_test;
    import fn_seq_pkg::*;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, run = 0, rev = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, relay, dout, bsa, dc, blk;
    logic [4:0] term = 0;
    logic [15:0] fcmd, ofreq, ref_fr = 16'h1388;
    logic [11:0] cur = 0, mcur;
    logic [13:0] v1 = 0, i2 = 0, v2 = 0;
    int fails = 0, cmp_count = 0, cyc = 0, n;
    fn_seq_top #(.TICK_CYCLES(4)) i_dut (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TERM_IN(term), .RUN_CMD(run), .REV_DIR(rev),
        .RUN_FREQ_REF(ref_fr), .OUT_FREQ(ofreq), .MOTOR_CURRENT(mcur), .AIN_V1(v1),
        .AIN_I2(i2), .AIN_V2(v2), .FREQ_CMD(fcmd), .RELAY1_OUT(relay), .DIGITAL_OUT1(dout),
        .BRAKE_SEQ_ACTIVE(bsa), .DC_BRAKE_ON(dc), .OUTPUT_BLOCK(blk));
    fn_seq_drive_model i_load (.clk(clk), .reset(reset), .freq_cmd(fcmd), .load_cur(cur),
        .out_freq(ofreq), .motor_cur(mcur));
    initial forever #25 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        if (!w)
            check(prdata, ed);
        check({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return relay;
            1: return dout;
            2: return dc;
            3: return blk;
            4: return fcmd == ref_fr;
            default: return fcmd == 16'h00c8;
        endcase
    endfunction
    // count cycles until the probed level appears, capped at lim
    task automatic wait_lvl(input int k, input logic lv, input int lim);
        n = 0;
        while (probe(k) !== lv && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_regs;
        apb(0, OFS_TIMER_DLY, 0, 32'h0064012c, 0);
        apb(0, OFS_ONOFF_LVL, 0, 32'h03e82328, 0);
        apb(0, OFS_ONOFF_SRC, 0, 32'h1, 0);
        apb(0, 8'h28, 0, 32'h0, 1);
        apb(1, OFS_IN_FUNC, 32'h37, 0, 1);
        apb(0, OFS_IN_FUNC, 0, 32'h0, 0);
        apb(1, OFS_ONOFF_LVL, 32'h00002711, 0, 1);
        apb(1, OFS_ONOFF_LVL, 32'h07d103e8, 0, 1);
        apb(0, OFS_ONOFF_LVL, 0, 32'h03e82328, 0);
    endtask
    task automatic t_timer;
        apb(1, OFS_OUT_FUNC, 32'h0000141c, 0, 0);
        apb(1, OFS_IN_FUNC, 32'h00026000, 0, 0);
        apb(1, OFS_TIMER_DLY, 32'h00030005, 0, 0);
        term <= 5'h04;
        repeat (8) @(posedge clk);
        term <= 5'h00;
        wait_lvl(0, 1, 40);
        check(n, 40);
        term <= 5'h04;
        wait_lvl(0, 1, 40);
        check(n >= 19 && n <= 28, 1);
        check(dout, 1);
        apb(0, OFS_STATUS, 0, 32'h00000119, 0);
        term <= 5'h00;
        wait_lvl(1, 0, 40);
        check(n >= 11 && n <= 19, 1);
    endtask
    task automatic t_onoff;
        apb(1, OFS_OUT_FUNC, 32'h00003618, 0, 0);
        apb(1, OFS_ONOFF_SRC, 32'h3, 0, 0);
        apb(1, OFS_ONOFF_LVL, 32'h07d01770, 0, 0);
        v1 <= 14'h270f;
        v2 <= 14'h1770;
        repeat (4) @(posedge clk);
        check({relay, dout}, 2'b11);
        v2 <= 14'h0fa0;
        repeat (4) @(posedge clk);
        check({relay, dout}, 2'b11);
        v2 <= 14'h07d0;
        repeat (4) @(posedge clk);
        check({relay, dout}, 2'b00);
    endtask
    task automatic t_brake;
        apb(1, OFS_OUT_FUNC, 32'h00003719, 0, 0);
        apb(1, OFS_BRK_CUR, 32'h0003012c, 0, 0);
        apb(1, OFS_BRK_REL_FR, 32'h00960064, 0, 0);
        apb(1, OFS_BRK_ENG, 32'h000200c8, 0, 0);
        apb(1, OFS_DC_BRK, 32'h00010002, 0, 0);
        check({bsa, blk}, 2'b11);
        rev <= 1'b1;
        cur <= 12'h064;
        run <= 1'b1;
        repeat (4) @(posedge clk);
        check(fcmd, 16'h0096);
        wait_lvl(0, 1, 20);
        check(n, 20);
        cur <= 12'h190;
        wait_lvl(0, 1, 10);
        check(n < 10 && dout === 1, 1);
        repeat (8) @(posedge clk);
        check(fcmd, 16'h0096);
        wait_lvl(4, 1, 20);
        check(n < 20, 1);
        run <= 1'b0;
        wait_lvl(5, 1, 400);
        check(n < 400, 1);
        wait_lvl(0, 0, 4);
        check(n < 4, 1);
        wait_lvl(2, 1, 16);
        check(n < 16, 1);
        @(posedge clk);
        check(fcmd, 16'h0000);
        wait_lvl(3, 1, 16);
        check(n < 16, 1);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs();
        t_timer();
        t_onoff();
        t_brake();
        complete_run();
    end
endmodule

//--- bench/fn_seq_drive_model.sv
// motor and brake load beside the sequencer: output frequency and current
// assumes one clock; frequency slews 32 steps per cycle, current set by the bench
`timescale 1ns/1ps
module fn_seq_drive_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] freq_cmd,
    input  wire logic [11:0] load_cur,
    output logic      [15:0] out_freq,
    output logic      [11:0] motor_cur
);
    // slow slew so frequency thresholds are crossed, not jumped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_freq  <= 16'h0;
            motor_cur <= 12'h0;
        end else begin
            if (out_freq + 16'h20 < freq_cmd)
                out_freq <= out_freq + 16'h20;
            else if (out_freq > freq_cmd + 16'h20)
                out_freq <= out_freq - 16'h20;
            else
                out_freq <= freq_cmd;
            motor_cur <= (freq_cmd != 16'h0) ? load_cur : 12'h0;
        end
    end
endmodule

//--- bench/fn_seq_top_props.sv
// checker on the sequencer ports: register refusals and brake state outputs
// assumes the single control clock and its active-high reset
`timescale 1ns/1ps
module fn_seq_top_props
    import fn_seq_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic        PSLVERR,
    input  wire logic        RUN_CMD,
    input  wire logic [15:0] FREQ_CMD,
    input  wire logic        DC_BRAKE_ON,
    input  wire logic        OUTPUT_BLOCK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    wire acc_wr = PSEL && PENABLE && PWRITE;
    property p_err_phase; PSLVERR |-> PSEL && PENABLE; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access");
    property p_code_max; acc_wr && PADDR == OFS_IN_FUNC && PWDATA[5:0] > CODE_IN_MAX
        |-> PSLVERR; endproperty
    a_code_max: assert property (p_code_max) else $error("bad code taken");
    property p_on_max; acc_wr && PADDR == OFS_ONOFF_LVL && PWDATA[13:0] > FULL_SCALE
        |-> PSLVERR; endproperty
    a_on_max: assert property (p_on_max) else $error("on level over scale taken");
    property p_off_on; acc_wr && PADDR == OFS_ONOFF_LVL && PWDATA[29:16] > PWDATA[13:0]
        |-> PSLVERR; endproperty
    a_off_on: assert property (p_off_on) else $error("off above on taken");
    property p_dc_blk; DC_BRAKE_ON |-> !OUTPUT_BLOCK; endproperty
    a_dc_blk: assert property (p_dc_blk) else $error("block during dc braking");
    property p_dc_end; $fell(DC_BRAKE_ON) |-> OUTPUT_BLOCK; endproperty
    a_dc_end: assert property (p_dc_end) else $error("no block after dc");
    property p_start; OUTPUT_BLOCK && RUN_CMD |=> !OUTPUT_BLOCK; endproperty
    a_start: assert property (p_start) else $error("run did not leave idle");
    property p_zero; OUTPUT_BLOCK [*3] |-> FREQ_CMD == 16'h0; endproperty
    a_zero: assert property (p_zero) else $error("frequency not zero at rest");
endmodule
bind fn_seq_top fn_seq_top_props i_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
    .RUN_CMD(RUN_CMD), .FREQ_CMD(FREQ_CMD), .DC_BRAKE_ON(DC_BRAKE_ON),
    .OUTPUT_BLOCK(OUTPUT_BLOCK));

//--- pkg/fn_seq_pkg.sv
// constants for the drive output function sequencer
// assumes one 20 MHz control clock; settings in 10 ms ticks, 0.01 Hz, 0.1 % and 0.01 %
package fn_seq_pkg;

    localparam int          CLK_HZ          = 20_000_000;
    localparam int          TICK_MS         = 10;
    localparam int          TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

    localparam logic [7:0]  OFS_IN_FUNC     = 8'h00;
    localparam logic [7:0]  OFS_OUT_FUNC    = 8'h04;
    localparam logic [7:0]  OFS_TIMER_DLY   = 8'h08;
    localparam logic [7:0]  OFS_BRK_CUR     = 8'h0c;
    localparam logic [7:0]  OFS_BRK_REL_FR  = 8'h10;
    localparam logic [7:0]  OFS_BRK_ENG     = 8'h14;
    localparam logic [7:0]  OFS_DC_BRK      = 8'h18;
    localparam logic [7:0]  OFS_ONOFF_SRC   = 8'h1c;
    localparam logic [7:0]  OFS_ONOFF_LVL   = 8'h20;
    localparam logic [7:0]  OFS_STATUS      = 8'h24;

    localparam int          IN_FIELD_W      = 6;
    localparam int          IN_TERMS        = 5;
    localparam logic [5:0]  CODE_TIMER_IN   = 6'h26;
    localparam logic [5:0]  CODE_IN_MAX     = 6'h36;
    localparam logic [7:0]  CODE_TIMER_A    = 8'h14;
    localparam logic [7:0]  CODE_TIMER_B    = 8'h1c;
    localparam logic [7:0]  CODE_BRAKE_A    = 8'h19;
    localparam logic [7:0]  CODE_BRAKE_B    = 8'h37;
    localparam logic [7:0]  CODE_ONOFF_A    = 8'h18;
    localparam logic [7:0]  CODE_ONOFF_B    = 8'h36;

    localparam logic [15:0] RST_T_ON        = 16'h012c;
    localparam logic [15:0] RST_T_OFF       = 16'h0064;
    localparam logic [15:0] MAX_T_DELAY     = 16'h2710;
    localparam logic [11:0] RST_BRK_CUR     = 12'h1f4;
    localparam logic [11:0] MAX_BRK_CUR     = 12'h708;
    localparam logic [15:0] RST_REL_HOLD    = 16'h0064;
    localparam logic [15:0] MAX_REL_HOLD    = 16'h03e8;
    localparam logic [15:0] RST_REL_FR      = 16'h0064;
    localparam logic [15:0] RST_ENG_FR      = 16'h00c8;
    localparam logic [15:0] RST_ENG_HOLD    = 16'h0064;
    localparam logic [15:0] MAX_ENG_HOLD    = 16'h03e8;
    localparam logic [1:0]  SRC_V1          = 2'h1;
    localparam logic [1:0]  SRC_I2          = 2'h2;
    localparam logic [1:0]  SRC_V2          = 2'h3;
    localparam logic [13:0] RST_ON_LVL      = 14'h2328;
    localparam logic [13:0] RST_OFF_LVL     = 14'h03e8;
    localparam logic [13:0] FULL_SCALE      = 14'h2710;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_RAMP     = 7'h02,
        ST_REL_HOLD = 7'h04,
        ST_RUN      = 7'h08,
        ST_DECEL    = 7'h10,
        ST_ENG_HOLD = 7'h20,
        ST_DC_BRAKE = 7'h40
    } state_type;

endpackage

//--- rtl/fn_seq_top.sv
// drive output function sequencer: timer, brake sequence, analog on/off control
// assumes synchronous inputs from the drive core and an APB master on the same clock
`timescale 1ns/1ps
module fn_seq_top
    import fn_seq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [4:0]  TERM_IN,
    input  wire logic        RUN_CMD,
    input  wire logic        REV_DIR,
    input  wire logic [15:0] RUN_FREQ_REF,
    input  wire logic [15:0] OUT_FREQ,
    input  wire logic [11:0] MOTOR_CURRENT,
    input  wire logic [13:0] AIN_V1,
    input  wire logic [13:0] AIN_I2,
    input  wire logic [13:0] AIN_V2,
    output logic      [15:0] FREQ_CMD,
    output logic             RELAY1_OUT,
    output logic             DIGITAL_OUT1,
    output logic             BRAKE_SEQ_ACTIVE,
    output logic             DC_BRAKE_ON,
    output logic             OUTPUT_BLOCK
);

    function automatic logic is_brake(input logic [7:0] code);
        is_brake = (code == CODE_BRAKE_A) || (code == CODE_BRAKE_B);
    endfunction

    // both timer-output codes are taken, the two printed values disagree
    function automatic logic route_out(input logic [7:0] code, input logic t,
                                       input logic b, input logic o);
        if ((code == CODE_TIMER_A) || (code == CODE_TIMER_B))
            route_out = t;
        else if (is_brake(code))
            route_out = b;
        else if ((code == CODE_ONOFF_A) || (code == CODE_ONOFF_B))
            route_out = o;
        else
            route_out = 1'b0;
    endfunction

    function automatic logic in_codes_ok(input logic [29:0] v);
        in_codes_ok = 1'b1;
        for (int k = 0; k < IN_TERMS; k++) begin
            if (v[IN_FIELD_W*k +: IN_FIELD_W] > CODE_IN_MAX)
                in_codes_ok = 1'b0;
        end
    endfunction

    logic [17:0] div_reg;
    logic [29:0] in_func_reg;
    logic [15:0] out_func_reg;
    logic [15:0] t_on_reg;
    logic [15:0] t_off_reg;
    logic [11:0] brk_cur_reg;
    logic [15:0] rel_hold_reg;
    logic [15:0] rel_fwd_reg;
    logic [15:0] rel_rev_reg;
    logic [15:0] eng_fr_reg;
    logic [15:0] eng_hold_reg;
    logic [15:0] dc_time_reg;
    logic [15:0] dc_level_reg;
    logic [1:0]  src_reg;
    logic [13:0] on_lvl_reg;
    logic [13:0] off_lvl_reg;
    logic [31:0] prdata_reg;
    logic        tout_reg;
    logic        onoff_reg;
    logic        relay_reg;
    logic        dout_reg;
    logic [15:0] freq_reg;
    state_type   state_reg;
    state_type   state_next;
    logic [15:0] freq_next;
    logic        brake_rel;

    wire         tick = (div_reg == 18'(TICK_CYCLES - 1));

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            div_reg <= 18'h00000;
        else
            div_reg <= tick ? 18'h00000 : div_reg + 18'h00001;
    end

    // bus decode
    wire         access   = PSEL && PENABLE;
    wire         wr       = access && PWRITE;
    wire         sel_in   = (PADDR == OFS_IN_FUNC);
    wire         sel_out  = (PADDR == OFS_OUT_FUNC);
    wire         sel_tdly = (PADDR == OFS_TIMER_DLY);
    wire         sel_cur  = (PADDR == OFS_BRK_CUR);
    wire         sel_rfr  = (PADDR == OFS_BRK_REL_FR);
    wire         sel_eng  = (PADDR == OFS_BRK_ENG);
    wire         sel_dc   = (PADDR == OFS_DC_BRK);
    wire         sel_src  = (PADDR == OFS_ONOFF_SRC);
    wire         sel_lvl  = (PADDR == OFS_ONOFF_LVL);
    wire         sel_st   = (PADDR == OFS_STATUS);
    wire         mapped   = sel_in | sel_out | sel_tdly | sel_cur | sel_rfr
                          | sel_eng | sel_dc | sel_src | sel_lvl | sel_st;

    // out-of-range settings are refused whole, the old value stays
    wire         bad_in   = sel_in && !in_codes_ok(PWDATA[29:0]);
    wire         bad_tdly = sel_tdly && ((PWDATA[15:0] > MAX_T_DELAY)
                          || (PWDATA[31:16] > MAX_T_DELAY));
    wire         bad_cur  = sel_cur && ((PWDATA[11:0] > MAX_BRK_CUR)
                          || (PWDATA[31:16] > MAX_REL_HOLD));
    wire         bad_eng  = sel_eng && (PWDATA[31:16] > MAX_ENG_HOLD);
    wire         bad_lvl  = sel_lvl && ((PWDATA[13:0] > FULL_SCALE)
                          || (PWDATA[29:16] > PWDATA[13:0]));
    wire         bad_wr   = bad_in | bad_tdly | bad_cur | bad_eng | bad_lvl;
    wire         wr_ok    = wr && !bad_wr;

    assign PREADY  = 1'b1;
    assign PSLVERR = access && (!mapped || (PWRITE && bad_wr));
    assign PRDATA  = prdata_reg;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            in_func_reg  <= 30'h00000000;
            out_func_reg <= 16'h0000;
            src_reg      <= SRC_V1;
        end else if (wr_ok) begin
            if (sel_in)
                in_func_reg <= PWDATA[29:0];
            if (sel_out)
                out_func_reg <= PWDATA[15:0];
            if (sel_src)
                src_reg <= PWDATA[1:0];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            t_on_reg     <= RST_T_ON;
            t_off_reg    <= RST_T_OFF;
            brk_cur_reg  <= RST_BRK_CUR;
            rel_hold_reg <= RST_REL_HOLD;
        end else if (wr_ok && sel_tdly) begin
            t_on_reg  <= PWDATA[15:0];
            t_off_reg <= PWDATA[31:16];
        end else if (wr_ok && sel_cur) begin
            brk_cur_reg  <= PWDATA[11:0];
            rel_hold_reg <= PWDATA[31:16];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rel_fwd_reg  <= RST_REL_FR;
            rel_rev_reg  <= RST_REL_FR;
            eng_fr_reg   <= RST_ENG_FR;
            eng_hold_reg <= RST_ENG_HOLD;
        end else if (wr_ok && sel_rfr) begin
            rel_fwd_reg <= PWDATA[15:0];
            rel_rev_reg <= PWDATA[31:16];
        end else if (wr_ok && sel_eng) begin
            eng_fr_reg   <= PWDATA[15:0];
            eng_hold_reg <= PWDATA[31:16];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            dc_time_reg  <= 16'h0000;
            dc_level_reg <= 16'h0000;
            on_lvl_reg   <= RST_ON_LVL;
            off_lvl_reg  <= RST_OFF_LVL;
        end else if (wr_ok && sel_dc) begin
            dc_time_reg  <= PWDATA[15:0];
            dc_level_reg <= PWDATA[31:16];
        end else if (wr_ok && sel_lvl) begin
            on_lvl_reg  <= PWDATA[13:0];
            off_lvl_reg <= PWDATA[29:16];
        end
    end

    // read data captured in the setup cycle so PRDATA comes from a flop
    wire  [31:0] status_word = {17'h00000, state_reg, 3'h0, dout_reg, relay_reg,
                                brake_rel, onoff_reg, tout_reg};
    wire  [31:0] rd_mux =
          sel_in   ? {2'h0, in_func_reg}                :
          sel_out  ? {16'h0000, out_func_reg}           :
          sel_tdly ? {t_off_reg, t_on_reg}              :
          sel_cur  ? {rel_hold_reg, 4'h0, brk_cur_reg}  :
          sel_rfr  ? {rel_rev_reg, rel_fwd_reg}         :
          sel_eng  ? {eng_hold_reg, eng_fr_reg}         :
          sel_dc   ? {dc_level_reg, dc_time_reg}        :
          sel_src  ? {30'h00000000, src_reg}            :
          sel_lvl  ? {2'h0, off_lvl_reg, 2'h0, on_lvl_reg} :
          sel_st   ? status_word                        : 32'h00000000;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            prdata_reg <= 32'h00000000;
        else if (PSEL && !PENABLE && !PWRITE)
            prdata_reg <= rd_mux;
    end

    logic [4:0] trig_hit;
    generate
        for (genvar i = 0; i < IN_TERMS; i++) begin : g_trig
            assign trig_hit[i] = TERM_IN[i]
                && (in_func_reg[IN_FIELD_W*i +: IN_FIELD_W] == CODE_TIMER_IN);
        end
    endgenerate
    wire         trig   = |trig_hit;
    wire         on_run = trig && !tout_reg;
    wire         off_run = !trig && tout_reg;
    logic        on_done;
    logic        off_done;

    // on-delay restarts from zero whenever the trigger drops
    tick_delay u_on_dly (
        .clk   (CLK),
        .reset (RESET),
        .tick  (tick),
        .run   (on_run),
        .limit (t_on_reg),
        .done  (on_done)
    );

    // off-delay, cancelled if the trigger comes back
    tick_delay u_off_dly (
        .clk   (CLK),
        .reset (RESET),
        .tick  (tick),
        .run   (off_run),
        .limit (t_off_reg),
        .done  (off_done)
    );

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            tout_reg <= 1'b0;
        else if (on_done)
            tout_reg <= 1'b1;
        else if (off_done)
            tout_reg <= 1'b0;
    end

    // brake sequencer
    wire         brake_en  = is_brake(out_func_reg[7:0]) || is_brake(out_func_reg[15:8]);
    wire  [15:0] rel_fr    = REV_DIR ? rel_rev_reg : rel_fwd_reg;
    wire         at_rel    = (OUT_FREQ >= rel_fr);
    wire         cur_ok    = (MOTOR_CURRENT >= brk_cur_reg);
    wire         at_eng    = (OUT_FREQ <= eng_fr_reg);
    wire         dc_cfg    = (dc_time_reg != 16'h0000) && (dc_level_reg != 16'h0000);
    assign       brake_rel = (state_reg == ST_REL_HOLD) || (state_reg == ST_RUN)
                          || (state_reg == ST_DECEL);
    logic        rel_done;
    logic        eng_done;
    logic        dc_done;

    tick_delay u_rel_dly (
        .clk   (CLK),
        .reset (RESET),
        .tick  (tick),
        .run   (state_reg == ST_REL_HOLD),
        .limit (rel_hold_reg),
        .done  (rel_done)
    );

    tick_delay u_eng_dly (
        .clk   (CLK),
        .reset (RESET),
        .tick  (tick),
        .run   (state_reg == ST_ENG_HOLD),
        .limit (eng_hold_reg),
        .done  (eng_done)
    );

    tick_delay u_dc_dly (
        .clk   (CLK),
        .reset (RESET),
        .tick  (tick),
        .run   (state_reg == ST_DC_BRAKE),
        .limit (dc_time_reg),
        .done  (dc_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (RUN_CMD)
                    state_next = ST_RAMP;
            end
            ST_RAMP: begin
                if (!RUN_CMD)
                    state_next = ST_IDLE;
                else if (at_rel && cur_ok)
                    state_next = ST_REL_HOLD;
            end
            ST_REL_HOLD: begin
                if (!RUN_CMD)
                    state_next = ST_DECEL;
                else if (rel_done)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (!RUN_CMD)
                    state_next = ST_DECEL;
            end
            ST_DECEL: begin
                if (RUN_CMD)
                    state_next = ST_RUN;
                else if (at_eng)
                    state_next = ST_ENG_HOLD;
            end
            ST_ENG_HOLD: begin
                if (eng_done)
                    state_next = dc_cfg ? ST_DC_BRAKE : ST_IDLE;
            end
            ST_DC_BRAKE: begin
                if (dc_done)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        if (!brake_en)
            state_next = ST_IDLE;
    end

    // without brake control the reference passes through while RUN_CMD is high, zero otherwise
    always_comb begin
        case (state_reg)
            ST_RAMP:     freq_next = rel_fr;
            ST_REL_HOLD: freq_next = rel_fr;
            ST_RUN:      freq_next = RUN_FREQ_REF;
            ST_DECEL:    freq_next = 16'h0000;
            ST_ENG_HOLD: freq_next = eng_fr_reg;
            ST_DC_BRAKE: freq_next = 16'h0000;
            default:     freq_next = 16'h0000;
        endcase
        if (!brake_en)
            freq_next = RUN_CMD ? RUN_FREQ_REF : 16'h0000;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
            freq_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            freq_reg  <= freq_next;
        end
    end

    // source select, unknown codes fall back to the first voltage input
    wire  [13:0] ana = (src_reg == SRC_I2) ? AIN_I2 :
                       (src_reg == SRC_V2) ? AIN_V2 : AIN_V1;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            onoff_reg <= 1'b0;
        else if (ana >= on_lvl_reg)
            onoff_reg <= 1'b1;
        else if (ana <= off_lvl_reg)
            onoff_reg <= 1'b0;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            relay_reg <= 1'b0;
            dout_reg  <= 1'b0;
        end else begin
            relay_reg <= route_out(out_func_reg[7:0], tout_reg, brake_rel, onoff_reg);
            dout_reg  <= route_out(out_func_reg[15:8], tout_reg, brake_rel, onoff_reg);
        end
    end

    assign RELAY1_OUT   = relay_reg;
    assign DIGITAL_OUT1 = dout_reg;
    assign FREQ_CMD     = freq_reg;
    // output held off in ST_IDLE only, not during DC braking or dwell
    assign BRAKE_SEQ_ACTIVE = brake_en;
    assign DC_BRAKE_ON  = (state_reg == ST_DC_BRAKE);
    assign OUTPUT_BLOCK = brake_en && (state_reg == ST_IDLE);

endmodule

//--- rtl/tick_delay.sv
// delay counter in 10 ms ticks, restarted whenever run falls
// assumes tick is a one-cycle enable from the shared divider
`timescale 1ns/1ps
module tick_delay
    import fn_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic [15:0] limit,
    output logic             done
);
    logic [16:0] count_reg;

    // counts saturate so a long run never wraps back to not-done
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            count_reg <= 17'h00000;
        else if (!run)
            count_reg <= 17'h00000;
        else if (tick && !count_reg[16])
            count_reg <= count_reg + 17'h00001;
    end

    // strictly greater: divider phase is free, so at least limit full ticks pass
    assign done = run && (count_reg > {1'b0, limit});
endmodule
